// ### pkg/cde_pkg.sv
// shared types, constants and helpers of the console deposit/examine handler
package cde_pkg;
	// access data size, encoded as log2 of the byte count
	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00,
		SZ_WORD = 2'b01,
		SZ_LONG = 2'b10,
		SZ_QUAD = 2'b11
	} cde_size_type;
	// address spaces; psw and vector control are target-only spaces
	typedef enum logic [2:0] {
		SP_PHYS = 3'b000,
		SP_VIRT = 3'b001,
		SP_GREG = 3'b010,
		SP_IPR = 3'b011,
		SP_VREG = 3'b100,
		SP_VIND = 3'b101,
		SP_PSW = 3'b110,
		SP_VCTL = 3'b111
	} cde_space_type;
	// kind of address operand delivered by the command parser
	typedef enum logic [3:0] {
		AK_NUM = 4'b0000,
		AK_PSW = 4'b0001,
		AK_PC = 4'b0010,
		AK_SP = 4'b0011,
		AK_GREG = 4'b0100,
		AK_VCR = 4'b0101,
		AK_VLR = 4'b0110,
		AK_VMR = 4'b0111,
		AK_VELEM = 4'b1000,
		AK_NEXT = 4'b1001,
		AK_PREV = 4'b1010,
		AK_LAST = 4'b1011,
		AK_IND = 4'b1100,
		AK_NONE = 4'b1101
	} cde_kind_type;
	// error codes reported per command
	typedef enum logic [3:0] {
		ER_NONE = 4'b0000,
		ER_CONFLICT = 4'b0001,
		ER_FIT = 4'b0010,
		ER_PSW_QUAL = 4'b0011,
		ER_VCTL_QUAL = 4'b0100,
		ER_VEC_SPACE = 4'b0101,
		ER_NO_VEC = 4'b0110,
		ER_VIND_RANGE = 4'b0111,
		ER_DENIED = 4'b1000
	} cde_err_type;
	// one-hot qualifier bit positions
	localparam int QB_BYTE = 0;
	localparam int QB_WORD = 1;
	localparam int QB_LONG = 2;
	localparam int QB_QUAD = 3;
	localparam int QS_PHYS = 0;
	localparam int QS_VIRT = 1;
	localparam int QS_GREG = 2;
	localparam int QS_IPR = 3;
	localparam int QS_VREG = 4;
	localparam int QS_VIND = 5;
	// register offsets (byte addresses)
	localparam logic [4:0] REG_CTRL_OFS = 5'h00;
	localparam logic [4:0] REG_STATUS_OFS = 5'h04;
	localparam logic [4:0] REG_LAST_ADDR_OFS = 5'h08;
	localparam logic [4:0] REG_DATA_LO_OFS = 5'h0C;
	localparam logic [4:0] REG_DATA_HI_OFS = 5'h10;
	// field positions
	localparam int CTRL_VEC_BIT = 0;
	localparam int CTRL_MM_BIT = 1;
	localparam int ST_SPACE_LSB = 0;
	localparam int ST_SIZE_LSB = 3;
	localparam int ST_BUSY_BIT = 5;
	localparam int ST_ERR_LSB = 8;
	// reset values after processor initialization
	localparam cde_space_type RST_SPACE = SP_PHYS;
	localparam cde_size_type RST_SIZE = SZ_LONG;
	localparam logic [31:0] RST_ADDR = 32'h0000_0000;
	localparam logic [1:0] RST_CTRL = 2'h0;
	// fixed register numbers and limits
	localparam logic [3:0] GREG_PC_NUM = 4'hF;
	localparam logic [3:0] GREG_SP_NUM = 4'hE;
	localparam logic [31:0] VCTL_VCR_ADDR = 32'h0000_0000;
	localparam logic [31:0] VCTL_VLR_ADDR = 32'h0000_0001;
	localparam logic [31:0] VCTL_VMR_ADDR = 32'h0000_0002;
	localparam logic [6:0] VCTL_NARROW_WIDTH = 7'h07;
	localparam logic [6:0] VMR_WIDTH = 7'h40;
	localparam logic [31:0] VIND_MIN = 32'h0000_0400;
	localparam logic [31:0] VIND_MAX = 32'h0000_0FFF;

	// address step: access size for memory spaces, one elsewhere
	function automatic logic [31:0] cde_step(cde_space_type sp,
		cde_size_type sz);
		if (sp == SP_PHYS || sp == SP_VIRT)
			cde_step = 32'h0000_0001 << sz;
		else
			cde_step = 32'h0000_0001;
	endfunction
endpackage

// ### design/cde_target.sv
// resolves the address operand into a target space and address
`timescale 1ns/1ps
module cde_target
	import cde_pkg::*;
(
	input wire cde_kind_type kind, // operand kind
	input wire logic [31:0] num_addr, // numeric address
	input wire logic [3:0] reg_num, // register number
	input wire logic [5:0] elem, // vector element
	input wire cde_space_type space_eff, // qualifier or saved space
	input wire logic space_given, // a space qualifier was typed
	input wire logic vec_ok, // vector processor attached
	input wire logic [31:0] last_addr, // last referenced address
	input wire cde_size_type last_size, // saved data size
	output cde_space_type res_space, // resolved space
	output logic [31:0] res_addr, // resolved address
	output logic [6:0] res_width, // fixed width, zero if by size
	output logic res_indirect, // address comes from a read
	output cde_err_type res_err // resolution error
);
	wire logic [31:0] step; // step of the saved reference
	wire logic vec_sp; // effective space is a vector one
	wire logic vind_bad; // vector indirect address out of range

	assign step = cde_step(space_eff, last_size);
	assign vec_sp = (space_eff == SP_VREG) || (space_eff == SP_VIND);
	assign vind_bad = (num_addr < VIND_MIN) || (num_addr > VIND_MAX);

	// operand decode; errors override the target
	always_comb
	begin
		res_space = space_eff;
		res_addr = last_addr;
		res_width = 7'h00;
		res_indirect = 1'b0;
		res_err = ER_NONE;
		case (kind)
			AK_NUM:
			begin
				res_addr = num_addr;
				if (vec_sp && !vec_ok)
					res_err = ER_NO_VEC;
				else if (space_eff == SP_VIND && vind_bad)
					res_err = ER_VIND_RANGE;
			end
			AK_PSW:
			begin
				res_space = SP_PSW;
				res_addr = RST_ADDR;
				if (space_given)
					res_err = ER_PSW_QUAL;
			end
			AK_PC, AK_SP, AK_GREG:
			begin
				res_space = SP_GREG;
				res_addr = {28'h000_0000, (kind == AK_PC) ? GREG_PC_NUM :
					(kind == AK_SP) ? GREG_SP_NUM : reg_num};
			end
			AK_VCR, AK_VLR, AK_VMR:
			begin
				res_space = SP_VCTL;
				res_addr = (kind == AK_VCR) ? VCTL_VCR_ADDR :
					(kind == AK_VLR) ? VCTL_VLR_ADDR : VCTL_VMR_ADDR;
				res_width = (kind == AK_VMR) ? VMR_WIDTH :
					VCTL_NARROW_WIDTH;
				if (space_given)
					res_err = ER_VCTL_QUAL;
				else if (!vec_ok)
					res_err = ER_NO_VEC;
			end
			AK_VELEM:
			begin
				res_addr = {22'h00_0000, reg_num, elem};
				if (space_eff != SP_VREG)
					res_err = ER_VEC_SPACE;
				else if (!vec_ok)
					res_err = ER_NO_VEC;
			end
			AK_NEXT, AK_NONE:
				res_addr = last_addr + step;
			AK_PREV:
				res_addr = last_addr - step;
			AK_LAST:
				res_addr = last_addr;
			AK_IND:
				res_indirect = 1'b1;
			default:
				res_addr = last_addr;
		endcase
	end
endmodule

// ### design/cde_console.sv
// console deposit/examine command handler, top level
//
// Summary of operation
// - byte, word, longword, quadword sizes; longword default
// - six address spaces; physical memory default
// - repeat count steps upward from start
// - next location adds access size in memory
// - previous location subtracts access size in memory
// - other spaces step next/previous by one
// - repeat-last and indirect symbols resolve from last
// - missing qualifiers reuse previous size and space
// - initialization: physical, longword, address zero
// - oversize deposit value: no write, error
// - narrow deposit value is zero-extended
// - conflicting qualifiers: discard command, error
// - pc, sp, general register force register space
// - status word target refuses space qualifier
// - count/length 7 bits, mask 64; unqualified
// - vector element needs vector space selected
// - vector registers default to quadword
// - indirect vector addresses 400 to FFF; needs vector unit
// - virtual access checked; denied gives error
// - mapped virtual write sets modified bit, flushes buffer
// - examine reads location; address optional
`timescale 1ns/1ps
module cde_console
	import cde_pkg::*;
#(
	parameter int CNT_W = 32 // width of the repeat count
)
(
	input wire logic core_clk, // system clock
	input wire logic rstn, // synchronous reset, active low
	// command port from the console parser
	input wire logic cmd_valid, // command offered
	output logic cmd_ready, // handler idle, takes command
	input wire logic cmd_write, // 1 deposit, 0 examine
	input wire logic [3:0] cmd_size_sel, // one-hot size qualifiers
	input wire logic [5:0] cmd_space_sel, // one-hot space qualifiers
	input wire logic [CNT_W-1:0] cmd_count, // repeat count, 0 none
	input wire cde_kind_type cmd_kind, // address operand kind
	input wire logic [31:0] cmd_addr, // numeric address
	input wire logic [3:0] cmd_reg, // register number
	input wire logic [5:0] cmd_elem, // vector element
	input wire logic [63:0] cmd_data, // deposit value
	// result port
	output logic done, // command finished, pulse
	output logic err, // command failed, pulse
	output cde_err_type err_code, // reason of last failure
	output logic exam_valid, // examine data valid, pulse
	output logic [63:0] exam_data, // examined contents
	// target access port
	output logic acc_req, // access request, level
	output logic acc_wr, // access is a write
	output cde_space_type acc_space, // target space
	output cde_size_type acc_size, // target size
	output logic [31:0] acc_addr, // target address
	output logic [63:0] acc_wdata, // write data
	input wire logic acc_ack, // access complete
	input wire logic acc_fault, // access denied
	input wire logic [63:0] acc_rdata, // read data
	output logic pte_mod_set, // set page_entry_modified_bit
	output logic wbuf_flush, // flush processor write buffer
	// register port
	input wire logic [4:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata // read data, next cycle
);
	////////////////////////////////////////////////////////////////////
	// state and storage
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_IND = 2'b01,
		ST_ACC = 2'b10
	} cde_state_type;

	cde_state_type state_reg, state_next; // sequencer
	cde_space_type cur_space_reg; // saved space qualifier
	cde_size_type cur_size_reg; // saved size qualifier
	logic [31:0] last_addr_reg; // last referenced location
	logic [1:0] ctrl_reg; // vector attached, mapping on
	cde_space_type tgt_space_reg; // space of running command
	cde_size_type tgt_size_reg; // size of running command
	logic [31:0] tgt_addr_reg; // current address
	logic [63:0] tgt_data_reg; // extended deposit value
	logic tgt_wr_reg; // running command writes
	logic [CNT_W-1:0] remain_reg; // accesses still to go after the current one
	logic done_reg, err_reg, exv_reg; // result pulses
	cde_err_type err_code_reg; // last error
	logic [63:0] exam_data_reg; // examined value
	logic pte_reg; // mapped virtual write seen
	logic [31:0] rdata_reg; // register read data
	////////////////////////////////////////////////////////////////////
	// qualifier decode
	wire logic size_given; // any size qualifier typed
	wire logic space_given; // any space qualifier typed
	wire logic size_conflict; // more than one size
	wire logic space_conflict; // more than one space
	wire cde_size_type size_q; // typed size
	wire cde_space_type space_q; // typed space
	wire cde_space_type space_eff; // typed or saved space
	wire logic vec_ok; // vector unit present
	wire logic mm_on; // memory mapping enabled

	// more than one bit set in a one-hot field
	function automatic logic multi_hot(logic [5:0] v);
		multi_hot = (v & (v - 6'h01)) != 6'h00;
	endfunction

	assign vec_ok = ctrl_reg[CTRL_VEC_BIT];
	assign mm_on = ctrl_reg[CTRL_MM_BIT];
	assign size_given = |cmd_size_sel;
	assign space_given = |cmd_space_sel;
	assign size_conflict = multi_hot({2'b00, cmd_size_sel});
	assign space_conflict = multi_hot(cmd_space_sel);
	assign size_q = cmd_size_sel[QB_QUAD] ? SZ_QUAD :
		cmd_size_sel[QB_LONG] ? SZ_LONG :
		cmd_size_sel[QB_WORD] ? SZ_WORD : SZ_BYTE;
	assign space_q = cmd_space_sel[QS_VIND] ? SP_VIND :
		cmd_space_sel[QS_VREG] ? SP_VREG :
		cmd_space_sel[QS_IPR] ? SP_IPR :
		cmd_space_sel[QS_GREG] ? SP_GREG :
		cmd_space_sel[QS_VIRT] ? SP_VIRT : SP_PHYS;
	assign space_eff = space_given ? space_q : cur_space_reg;
	////////////////////////////////////////////////////////////////////
	// operand resolution
	wire cde_space_type res_space; // resolved space
	wire logic [31:0] res_addr; // resolved address
	wire logic [6:0] res_width; // fixed width or zero
	wire logic res_ind; // indirect operand
	wire cde_err_type res_err; // resolution error

	cde_target u_target (
		.kind(cmd_kind),
		.num_addr(cmd_addr),
		.reg_num(cmd_reg),
		.elem(cmd_elem),
		.space_eff(space_eff),
		.space_given(space_given),
		.vec_ok(vec_ok),
		.last_addr(last_addr_reg),
		.last_size(cur_size_reg),
		.res_space(res_space),
		.res_addr(res_addr),
		.res_width(res_width),
		.res_indirect(res_ind),
		.res_err(res_err)
	);

	wire cde_size_type size_eff; // size for this command
	wire logic [6:0] width_eff; // data width in bits
	wire logic [63:0] width_mask; // ones over the data width
	wire logic fit_bad; // deposit value too wide
	wire cde_err_type cmd_err; // final verdict on the command
	wire logic saves_qual; // target space is a saved space

	// vector registers take quadword unless a size was typed
	assign size_eff = size_given ? size_q :
		(res_space == SP_VREG) ? SZ_QUAD : cur_size_reg;
	assign width_eff = (res_width != 7'h00) ? res_width :
		7'(7'h08 << size_eff);
	assign width_mask = (width_eff == VMR_WIDTH) ? 64'hFFFF_FFFF_FFFF_FFFF :
		((64'h0000_0000_0000_0001 << width_eff) - 64'h0000_0000_0000_0001);
	assign fit_bad = cmd_write && ((cmd_data & ~width_mask) != 64'h0);
	// conflict outranks every other verdict, nothing is touched
	assign cmd_err = (size_conflict || space_conflict) ? ER_CONFLICT :
		(res_err != ER_NONE) ? res_err :
		fit_bad ? ER_FIT : ER_NONE;
	assign saves_qual = (res_space != SP_PSW) && (res_space != SP_VCTL);
	////////////////////////////////////////////////////////////////////
	// sequencer
	wire logic take; // command accepted this cycle
	wire logic acc_done; // access answered
	wire logic acc_last; // final access of a repeat
	wire logic virt_map; // virtual access through the map

	assign take = cmd_valid && (state_reg == ST_IDLE);
	assign acc_done = acc_ack && (state_reg != ST_IDLE);
	assign acc_last = remain_reg == '0;
	assign virt_map = (tgt_space_reg == SP_VIRT) && mm_on;

	// next state; a fault ends the command at once
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (take && cmd_err == ER_NONE)
					state_next = res_ind ? ST_IND : ST_ACC;
			ST_IND:
				if (acc_ack)
					state_next = acc_fault ? ST_IDLE : ST_ACC;
			ST_ACC:
				if (acc_ack && (acc_fault || acc_last))
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// saved qualifiers and last location survive between commands
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			cur_space_reg <= RST_SPACE;
			cur_size_reg <= RST_SIZE;
		end
		else if (take && cmd_err == ER_NONE && saves_qual)
		begin
			cur_space_reg <= res_space;
			cur_size_reg <= size_eff;
		end
	end
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			last_addr_reg <= RST_ADDR;
		else if (state_reg == ST_ACC && acc_ack && !acc_fault)
			last_addr_reg <= tgt_addr_reg;
	end

	// target of the running command
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			tgt_space_reg <= RST_SPACE;
			tgt_size_reg <= RST_SIZE;
			tgt_addr_reg <= RST_ADDR;
			tgt_data_reg <= 64'h0000_0000_0000_0000;
			tgt_wr_reg <= 1'b0;
			remain_reg <= '0;
		end
		else if (take)
		begin
			tgt_space_reg <= res_space;
			tgt_size_reg <= size_eff;
			// indirect: first fetch the pointer at the last location
			tgt_addr_reg <= res_ind ? last_addr_reg : res_addr;
			tgt_data_reg <= cmd_data & width_mask;
			tgt_wr_reg <= cmd_write;
			remain_reg <= cmd_count;
		end
		else if (state_reg == ST_IND && acc_ack)
			tgt_addr_reg <= acc_rdata[31:0];
		else if (state_reg == ST_ACC && acc_ack && !acc_last)
		begin
			// repeats always climb, whatever symbol gave the start
			tgt_addr_reg <= tgt_addr_reg +
				cde_step(tgt_space_reg, tgt_size_reg);
			remain_reg <= remain_reg - 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////
	// results
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			err_code_reg <= ER_NONE;
		end
		else
		begin
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			if (take && cmd_err != ER_NONE)
			begin
				err_reg <= 1'b1;
				err_code_reg <= cmd_err;
			end
			else if (acc_done && acc_fault)
			begin
				err_reg <= 1'b1;
				err_code_reg <= ER_DENIED;
			end
			else if (state_reg == ST_ACC && acc_ack && acc_last)
				done_reg <= 1'b1;
		end
	end

	// examined data, one pulse per location read
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			exv_reg <= 1'b0;
			exam_data_reg <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			exv_reg <= 1'b0;
			if (state_reg == ST_ACC && acc_ack && !acc_fault && !tgt_wr_reg)
			begin
				exv_reg <= 1'b1;
				exam_data_reg <= acc_rdata;
			end
		end
	end

	// one flop marks the page and drains the buffer, so they never part
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			pte_reg <= 1'b0;
		else
			pte_reg <= state_reg == ST_ACC && acc_ack && !acc_fault &&
				tgt_wr_reg && virt_map;
	end
	////////////////////////////////////////////////////////////////////
	// register port
	wire logic [31:0] status_word; // live status
	wire logic [31:0] rd_mux; // selected read value

	assign status_word = {20'h0_0000, err_code_reg, 2'b00,
		state_reg != ST_IDLE, cur_size_reg, cur_space_reg};
	assign rd_mux = (reg_addr == REG_CTRL_OFS) ? {30'h0000_0000, ctrl_reg} :
		(reg_addr == REG_STATUS_OFS) ? status_word :
		(reg_addr == REG_LAST_ADDR_OFS) ? last_addr_reg :
		(reg_addr == REG_DATA_LO_OFS) ? exam_data_reg[31:0] :
		(reg_addr == REG_DATA_HI_OFS) ? exam_data_reg[63:32] :
		32'h0000_0000; // unmapped reads zero

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			ctrl_reg <= RST_CTRL;
		else if (reg_wr && reg_addr == REG_CTRL_OFS)
			ctrl_reg <= reg_wdata[1:0];
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			rdata_reg <= 32'h0000_0000;
		else
			rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000; // one cycle only
	end
	////////////////////////////////////////////////////////////////////
	// outputs
	assign cmd_ready = state_reg == ST_IDLE;
	assign acc_req = state_reg != ST_IDLE;
	assign acc_wr = (state_reg == ST_ACC) && tgt_wr_reg;
	// unmapped virtual is plain physical, pointer fetch included
	assign acc_space = (tgt_space_reg == SP_VIRT && !mm_on) ? SP_PHYS :
		tgt_space_reg;
	assign acc_size = (state_reg == ST_IND) ? SZ_LONG : tgt_size_reg;
	assign acc_addr = tgt_addr_reg;
	assign acc_wdata = tgt_data_reg;
	assign done = done_reg;
	assign err = err_reg;
	assign err_code = err_code_reg;
	assign exam_valid = exv_reg;
	assign exam_data = exam_data_reg;
	assign pte_mod_set = pte_reg;
	assign wbuf_flush = pte_reg;
	assign reg_rdata = rdata_reg;
endmodule

// ### sim/cde_console_assertions.sv
// port checker of the console deposit/examine handler
`timescale 1ns/1ps
module cde_console_assertions
	import cde_pkg::*;
(
	input wire logic core_clk, // clock
	input wire logic rstn, // sync reset
	input wire logic cmd_valid, // offered
	input wire logic cmd_ready, // idle
	input wire logic cmd_write, // deposit
	input wire logic [3:0] cmd_size_sel, // sizes
	input wire logic [5:0] cmd_space_sel, // spaces
	input wire cde_kind_type cmd_kind, // operand
	input wire logic [31:0] cmd_addr, // address
	input wire logic [63:0] cmd_data, // value
	input wire logic done, // finished
	input wire logic err, // failed
	input wire cde_err_type err_code, // reason
	input wire logic exam_valid, // read data
	input wire logic [63:0] exam_data, // contents
	input wire logic acc_req, // request
	input wire logic acc_wr, // write
	input wire cde_space_type acc_space, // space
	input wire cde_size_type acc_size, // size
	input wire logic [31:0] acc_addr, // address
	input wire logic [63:0] acc_wdata, // data out
	input wire logic acc_ack, // complete
	input wire logic acc_fault, // denied
	input wire logic [63:0] acc_rdata, // data in
	input wire logic pte_mod_set, // modified
	input wire logic wbuf_flush // flush
);
	wire take = cmd_valid && cmd_ready; // command taken
	wire one = $onehot0(cmd_size_sel) && $onehot0(cmd_space_sel); // sane
	wire ackd = acc_req && acc_ack; // access completes
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////
	chk_size_conflict: assert property (take && !$onehot0(cmd_size_sel)
		|=> err && err_code == ER_CONFLICT && !acc_req) else $error("conflict");
	chk_fit_refuse: assert property (take && cmd_write && one
		&& cmd_size_sel == 4'h1 && cmd_space_sel == 6'h01
		&& cmd_kind == AK_NUM && |cmd_data[63:8]
		|=> err && err_code == ER_FIT && !acc_req) else $error("fit");
	chk_psw_qual: assert property (take && cmd_kind == AK_PSW && one
		&& |cmd_space_sel |=> err && err_code == ER_PSW_QUAL)
		else $error("status word qualifier");
	chk_greg_force: assert property (take && !cmd_write && one
		&& cmd_space_sel == 6'h00 && cmd_kind inside {AK_PC, AK_SP, AK_GREG}
		|=> acc_req && acc_space == SP_GREG) else $error("greg space");
	chk_phys_addr: assert property (take && !cmd_write && one
		&& cmd_space_sel == 6'h01 && cmd_kind == AK_NUM
		|=> acc_req && acc_space == SP_PHYS && acc_addr == $past(cmd_addr))
		else $error("phys address");
	// narrow writes carry zeros above the size; vector control sizes itself
	chk_zero_ext: assert property (acc_req && acc_wr && acc_size != SZ_QUAD
		&& acc_space != SP_VCTL |-> (acc_wdata >> (8 << acc_size)) == 64'h0)
		else $error("extend");
	chk_exam_data: assert property (exam_valid
		|-> $past(ackd) && exam_data == $past(acc_rdata)) else $error("exam");
	chk_virt_write: assert property (ackd && acc_wr && !acc_fault
		&& acc_space == SP_VIRT |=> pte_mod_set && wbuf_flush)
		else $error("virtual write side effects");
	chk_deny_err: assert property (ackd && acc_fault
		|=> err && err_code == ER_DENIED && !done) else $error("denied");
	chk_done_ack: assert property (done |-> $past(ackd))
		else $error("done without ack");
	// main scenarios reached
	cover property (ackd && acc_wr);
	cover property (err);
	cover property (exam_valid);
endmodule
bind cde_console cde_console_assertions u_chk (.core_clk, .rstn,
	.cmd_valid, .cmd_ready, .cmd_write, .cmd_size_sel, .cmd_space_sel,
	.cmd_kind, .cmd_addr, .cmd_data, .done, .err, .err_code, .exam_valid,
	.exam_data, .acc_req, .acc_wr, .acc_space, .acc_size, .acc_addr,
	.acc_wdata, .acc_ack, .acc_fault, .acc_rdata, .pte_mod_set, .wbuf_flush);

// ### sim/cde_target_model.sv
// behavioural target store behind the handler's access port
`timescale 1ns/1ps
module cde_target_model
(
	input wire logic core_clk, // clock
	input wire logic acc_req, // request
	input wire logic acc_wr, // write
	input wire logic [31:0] acc_addr, // address
	input wire logic [63:0] acc_wdata, // write data
	input wire logic fault_en, // deny accesses
	input wire logic slow, // stall three cycles
	output logic acc_ack, // done pulse
	output logic acc_fault, // denied
	output logic [63:0] acc_rdata // valid with ack only
);
	logic [63:0] mem [0:255]; // small store, low address byte only
	logic [1:0] wait_reg = 2'h0; // stall counter
	initial
	begin
		acc_ack = 1'h0;
		acc_fault = 1'h0;
		acc_rdata = 64'h0;
		for (int i = 0; i < 256; i++)
			mem[i] = 64'(i);
	end
	////////////////////////////////////////////////////////////////////
	// answer now or after stalls; data lines toggle between acks
	always @(posedge core_clk)
	begin
		acc_ack <= 1'h0;
		acc_fault <= 1'h0;
		acc_rdata <= ~acc_rdata;
		if (acc_req && !acc_ack && wait_reg != (slow ? 2'h3 : 2'h0))
			wait_reg <= wait_reg + 2'h1;
		else if (acc_req && !acc_ack)
		begin
			wait_reg <= 2'h0;
			acc_ack <= 1'h1;
			acc_fault <= fault_en;
			acc_rdata <= mem[acc_addr[7:0]];
			if (acc_wr && !fault_en)
				mem[acc_addr[7:0]] <= acc_wdata;
		end
	end
endmodule

// ### sim/cde_console_test.sv
// self-checking bench of the console deposit/examine handler
`timescale 1ns/1ps
module cde_console_test;
	import cde_pkg::*;
	logic core_clk = 1'h0, rstn = 1'h0, cmd_valid = 1'h0, cmd_write = 1'h0;
	logic reg_wr = 1'h0, reg_rd = 1'h0, fault_en = 1'h0, slow = 1'h1;
	logic [3:0] cmd_size_sel = '0, cmd_reg = '0;
	logic [5:0] cmd_space_sel = '0, cmd_elem = '0;
	logic [31:0] cmd_count = '0, cmd_addr = '0, reg_wdata = '0;
	logic [63:0] cmd_data = '0;
	logic [4:0] reg_addr = '0;
	cde_kind_type cmd_kind = AK_NONE;
	logic cmd_ready, done, err, exam_valid, acc_req, acc_wr, acc_ack;
	logic acc_fault, pte_mod_set, wbuf_flush, mod_seen = 1'h0;
	logic [63:0] exam_data, acc_wdata, acc_rdata, xd;
	logic [31:0] acc_addr, reg_rdata;
	logic [31:0] alog [$]; // addresses acked in this command
	cde_err_type err_code, ec;
	cde_space_type acc_space;
	cde_size_type acc_size, lsz;
	int bad_count = 0, check_count = 0, cyc = 0;
`define CK(a, e) begin check_count++; if ((a) !== (e)) begin \
	bad_count++; $display("wrong value at %0t: %h", $time, a); end end
	always #5 core_clk = ~core_clk;
	cde_console u_dut (.core_clk, .rstn, .cmd_valid, .cmd_ready, .cmd_write,
		.cmd_size_sel, .cmd_space_sel, .cmd_count, .cmd_kind, .cmd_addr,
		.cmd_reg, .cmd_elem, .cmd_data, .done, .err, .err_code, .exam_valid,
		.exam_data, .acc_req, .acc_wr, .acc_space, .acc_size, .acc_addr,
		.acc_wdata, .acc_ack, .acc_fault, .acc_rdata, .pte_mod_set,
		.wbuf_flush, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	cde_target_model u_tgt (.core_clk, .acc_req, .acc_wr, .acc_addr,
		.acc_wdata, .fault_en, .slow, .acc_ack, .acc_fault, .acc_rdata);
	////////////////////////////////////////////////////////////////////
	// watch the access port between edges
	always @(negedge core_clk)
	begin
		if (acc_req && acc_ack)
			alog.push_back(acc_addr);
		if (acc_req)
			lsz = acc_size;
		if (exam_valid)
			xd = exam_data;
		if (pte_mod_set && wbuf_flush)
			mod_seen = 1'h1;
	end
	// hang guard, far above the hundred or so cycles needed
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			results();
		end
	end
	task results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one command, then wait for its end; element fields ride on a[9:0]
	task run(input logic w, input logic [3:0] sz, input logic [5:0] sp,
		input logic [31:0] n, input cde_kind_type k, input logic [31:0] a,
		input logic [63:0] d);
		@(posedge core_clk);
		cmd_valid <= 1'h1;
		cmd_write <= w;
		cmd_size_sel <= sz;
		cmd_space_sel <= sp;
		cmd_count <= n;
		cmd_kind <= k;
		cmd_addr <= a;
		cmd_reg <= a[9:6];
		cmd_elem <= a[5:0];
		cmd_data <= d;
		alog.delete();
		@(posedge core_clk);
		cmd_valid <= 1'h0;
		for (int i = 0; i < 60 && !(done || err); i++)
			@(negedge core_clk);
		#1;
		if (!(done || err))
			bad_count++; // command never ended
		ec = err ? err_code : ER_NONE;
	endtask
	task rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		@(negedge core_clk);
		`CK(reg_rdata, e)
	endtask
	task wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'h1;
		rd(REG_STATUS_OFS, 32'h0000_0010);
		rd(REG_LAST_ADDR_OFS, 32'h0000_0000);
		rd(5'h14, 32'h0000_0000);
		run(0, 0, 6'h01, 2, AK_NUM, 32'h0000_0100, 0);
		`CK(alog.size(), 3)
		`CK(alog[2], 32'h0000_0108)
		slow = 1'h0;
		run(0, 0, 0, 0, AK_NEXT, 0, 0);
		`CK(alog[0], 32'h0000_010C)
		run(0, 4'h1, 0, 0, AK_LAST, 0, 0);
		`CK(alog[0], 32'h0000_010C)
		run(0, 0, 0, 1, AK_PREV, 0, 0);
		`CK(alog[0], 32'h0000_010B)
		`CK(alog[1], 32'h0000_010C)
		rd(REG_STATUS_OFS, 32'h0000_0000);
		run(1, 0, 6'h04, 0, AK_NUM, 32'h0000_0005, 0);
		run(0, 0, 0, 0, AK_NEXT, 0, 0);
		`CK(alog[0], 32'h0000_0006)
		run(0, 0, 0, 0, AK_NONE, 0, 0);
		`CK(alog[0], 32'h0000_0007)
		run(1, 4'h2, 6'h01, 0, AK_NUM, 32'h0000_0080, 64'h90);
		run(0, 4'h4, 0, 0, AK_LAST, 0, 0);
		`CK(xd, 64'h0000_0000_0000_0090)
		run(0, 0, 0, 0, AK_IND, 0, 0);
		`CK(alog[1], 32'h0000_0090)
		run(1, 4'h1, 6'h01, 0, AK_NUM, 32'h0000_0020, 64'h1FF);
		`CK(ec, ER_FIT)
		`CK(alog.size(), 0)
		run(0, 4'h3, 0, 0, AK_NUM, 0, 0);
		`CK(ec, ER_CONFLICT)
		run(0, 0, 6'h03, 0, AK_NUM, 0, 0);
		`CK(ec, ER_CONFLICT)
		run(0, 0, 6'h01, 0, AK_PSW, 0, 0);
		`CK(ec, ER_PSW_QUAL)
		run(0, 0, 0, 0, AK_PC, 0, 0);
		rd(REG_STATUS_OFS, 32'h0000_0312);
		run(0, 0, 0, 0, AK_VCR, 0, 0);
		`CK(ec, ER_NO_VEC)
		wr(REG_CTRL_OFS, 32'h0000_0001);
		run(0, 0, 6'h01, 0, AK_VCR, 0, 0);
		`CK(ec, ER_VCTL_QUAL)
		run(1, 0, 0, 0, AK_VLR, 0, 64'h80);
		`CK(ec, ER_FIT)
		run(0, 0, 0, 0, AK_VELEM, 32'h0000_00C5, 0);
		`CK(ec, ER_VEC_SPACE)
		run(0, 0, 6'h10, 0, AK_VELEM, 32'h0000_00C5, 0);
		`CK(alog[0], 32'h0000_00C5)
		`CK(lsz, SZ_QUAD)
		run(0, 0, 6'h20, 0, AK_NUM, 32'h0000_03FF, 0);
		`CK(ec, ER_VIND_RANGE)
		run(0, 0, 6'h20, 0, AK_NUM, 32'h0000_0400, 0);
		`CK(ec, ER_NONE)
		wr(REG_CTRL_OFS, 32'h0000_0003);
		run(1, 4'h4, 6'h02, 0, AK_NUM, 32'h0000_0040, 64'h7);
		`CK(mod_seen, 1'h1)
		fault_en = 1'h1;
		run(0, 0, 0, 0, AK_LAST, 0, 0);
		`CK(ec, ER_DENIED)
		results();
	end
endmodule
